/* src/mmc_mode_ctrl.sv */
// Metering mode control register with its serial port and reset sequencer.
// Assumes temperature, pulse and datapath logic run on sys_clk.
//
// What this block does
// - Bit 0 bypasses channel-1 high-pass filter.
// - Bit 1 bypasses post-multiplier low-pass filter.
// - Bit 2 stops the power pulse output.
// - Bit 3 disables line voltage dip detection.
// - Bit 4 powers down both converters.
// - Bit 5 starts temperature conversion, self-clears.
// - Bit 6 resets chip; host waits 18 us.
// - Bit 7 selects half-cycle energy accumulation.
// - Bit 8 shorts channel-1 converter inputs.
// - Bit 9 shorts channel-2 converter inputs.
// - Bit 10 swaps channel input pairs.
// - Bits 12:11 pick waveform rate divider.
// - Bits 14:13 pick waveform sample source.
// - Bit 15 enters factory test mode.
// - Mode register lives at address 0x06.
// - Command byte: low five address, top write.
// - Finished conversion sets status flag bit 5.
`timescale 1ns/10ps
module mmc_mode_ctrl
    import mmc_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Serial register pins
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       din,
    output logic            dout,
    // Datapath inputs
    input  wire logic       temp_done,
    input  wire logic [7:0] temp_result,
    input  wire logic       power_pulse_raw,
    // Filter and detector controls
    output logic            highpass_bypass,
    output logic            power_lowpass_bypass,
    output logic            dip_detect_disable,
    output logic            half_cycle_accumulate_mode,
    // Converter controls
    output logic            converter_powerdown,
    output logic            chan_a_input_short,
    output logic            chan_b_input_short,
    output logic            adc_input_swap,
    output logic            temperature_convert_start,
    output logic            factory_test_enable,
    // Waveform sampling
    output logic [1:0]      waveform_source_select,
    output logic [5:0]      waveform_sample_len,
    output logic            waveform_sample_strobe,
    // Pulse output and chip reset
    output logic            power_pulse_output,
    output logic            chip_reset_n
);

    logic [15:0]           mode;
    logic [7:0]            status;
    logic [SOFT_CNT_W-1:0] soft_cnt;
    logic [4:0]            acc_addr;
    logic [15:0]           wr_data;
    logic                  wr_pulse;
    logic                  rd_done;
    logic [SOFT_CNT_W-1:0] next_soft_cnt;

    // ********************************************************************
    // Decode of serial accesses
    // ********************************************************************
    wire        soft_busy   = (soft_cnt != '0);
    wire        core_rst_n  = rst_n & ~soft_busy;
    wire        mode_wr     = wr_pulse && (acc_addr == ADDR_MODE);
    wire        soft_go     = mode_wr && wr_data[BIT_SOFT_RST];
    wire        stat_clear  = rd_done && (acc_addr == ADDR_RSTSTATUS);
    wire [7:0]  stat_set    = {2'h0, temp_done, 5'h00};
    wire [7:0]  next_status = (stat_clear ? 8'h00 : status) | stat_set;
    wire [15:0] rd_mode     = {8'h00, status};
    wire [15:0] rd_data     = (acc_addr == ADDR_MODE)      ? mode :
                              (acc_addr == ADDR_STATUS)    ? rd_mode :
                              (acc_addr == ADDR_RSTSTATUS) ? rd_mode :
                              (acc_addr == ADDR_TEMP)      ? {8'h00, temp_result} :
                                                             16'h0000;

    // Soft reset counter load and count down
    assign next_soft_cnt = soft_go   ? SOFT_CNT_W'(SOFT_RESET_CYC) :
                           soft_busy ? soft_cnt - 1'b1 : soft_cnt;

    // ********************************************************************
    // Serial port and waveform divider
    // ********************************************************************
    mmc_serial_port u_port (
        .sys_clk  (sys_clk),
        .rst_n    (core_rst_n),
        .sclk     (sclk),
        .cs_n     (cs_n),
        .din      (din),
        .dout     (dout),
        .rd_data  (rd_data),
        .acc_addr (acc_addr),
        .wr_data  (wr_data),
        .wr_pulse (wr_pulse),
        .rd_done  (rd_done)
    );

    mmc_rate_div #(
        .DIV_W (RATE_DIV_W)
    ) u_rate (
        .sys_clk  (sys_clk),
        .rst_n    (core_rst_n),
        .rate_sel (mode[RATE_LSB +: 2]),
        .tick     (waveform_sample_strobe)
    );

    // ********************************************************************
    // Soft reset sequencer
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            soft_cnt     <= '0;
            chip_reset_n <= 1'b0;
        end else begin
            soft_cnt     <= next_soft_cnt;
            chip_reset_n <= (next_soft_cnt == '0);
        end
    end

    // ********************************************************************
    // Mode register
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!core_rst_n) begin
            mode <= MODE_RESET;
        end else if (mode_wr) begin
            mode <= wr_data;
        end else if (temp_done) begin
            mode[BIT_TEMP_START] <= 1'b0;
        end
    end

    // ********************************************************************
    // Status flags, set wins over read clear
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!core_rst_n) begin
            status <= STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // ********************************************************************
    // Gated pulse output and waveform word length
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!core_rst_n) begin
            power_pulse_output  <= 1'b0;
            waveform_sample_len <= WAVE_LEN_SHORT;
        end else begin
            power_pulse_output  <= power_pulse_raw & ~mode[BIT_PULSE_DIS];
            waveform_sample_len <= (mode[SRC_LSB +: 2] == WAVE_SRC_BOTH) ?
                                   WAVE_LEN_LONG : WAVE_LEN_SHORT;
        end
    end

    // Control outputs straight from mode flops
    assign highpass_bypass            = mode[BIT_HPF_BYP];
    assign power_lowpass_bypass       = mode[BIT_LPF_BYP];
    assign dip_detect_disable         = mode[BIT_DIP_DIS];
    assign converter_powerdown        = mode[BIT_ADC_PD];
    assign temperature_convert_start  = mode[BIT_TEMP_START];
    assign half_cycle_accumulate_mode = mode[BIT_HALF_CYC];
    assign chan_a_input_short         = mode[BIT_SHORT_A];
    assign chan_b_input_short         = mode[BIT_SHORT_B];
    assign adc_input_swap             = mode[BIT_SWAP];
    assign waveform_source_select     = mode[SRC_LSB +: 2];
    assign factory_test_enable        = mode[BIT_TEST];

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_mode_write_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (mode == $past(wr_data)))
        else $error("mode write not loaded next cycle");

    a_pulse_gate_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        mode[BIT_PULSE_DIS] |=> !power_pulse_output)
        else $error("pulse output active while disabled");

    a_temp_self_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (temp_done && mode[BIT_TEMP_START] && !mode_wr && !soft_busy)
        |=> (!temperature_convert_start && status[STAT_TEMP]))
        else $error("temperature start not cleared or flag not set");

    a_temp_flag_wins: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (temp_done && stat_clear && !soft_busy) |=> status[STAT_TEMP])
        else $error("temperature flag lost to read clear");

    a_soft_reset_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        soft_go |=> (!chip_reset_n && soft_busy)[*8])
        else $error("soft reset not held");

    a_soft_reset_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        soft_busy |=> (mode == MODE_RESET && !power_pulse_output))
        else $error("mode not cleared by chip reset");

    a_rate_tick_gap: assert property (
        @(posedge sys_clk) disable iff (!rst_n || soft_busy)
        (waveform_sample_strobe && !mode_wr) |=> !waveform_sample_strobe[*8])
        else $error("waveform strobes too close");

    a_bypass_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (highpass_bypass == $past(wr_data[BIT_HPF_BYP])
            && adc_input_swap == $past(wr_data[BIT_SWAP])))
        else $error("control outputs do not follow write");

    a_lowpass_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (power_lowpass_bypass == $past(wr_data[BIT_LPF_BYP])))
        else $error("lowpass bypass not loaded");

    a_dip_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (dip_detect_disable == $past(wr_data[BIT_DIP_DIS])))
        else $error("dip disable not loaded");

    a_powerdown_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (converter_powerdown == $past(wr_data[BIT_ADC_PD])))
        else $error("powerdown not loaded");

    a_half_cycle_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (half_cycle_accumulate_mode == $past(wr_data[BIT_HALF_CYC])))
        else $error("half cycle mode not loaded");

    a_test_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_wr && !soft_busy) |=> (factory_test_enable == $past(wr_data[BIT_TEST])))
        else $error("test mode not loaded");

    a_sample_len_long: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (waveform_source_select == WAVE_SRC_BOTH && !soft_busy)
        |=> (waveform_sample_len == WAVE_LEN_LONG))
        else $error("waveform length not long");

    a_chip_reset_out: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        soft_busy |-> !chip_reset_n)
        else $error("chip reset released in soft window");

    a_other_write_kept: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_pulse && acc_addr != ADDR_MODE && !temp_done) |=> (mode == $past(mode)))
        else $error("mode changed by other address");

endmodule : mmc_mode_ctrl

/* src/mmc_pkg.sv */
// Constants, register map and field layout of the metering mode control block.
// Assumes a single 100 MHz system clock shared by every module that imports it.
package mmc_pkg;

    // ********************************************************************
    // Register addresses (five-bit command address)
    // ********************************************************************
    localparam int          ADDR_W          = 5;
    localparam logic [4:0]  ADDR_STATUS     = 5'h04;
    localparam logic [4:0]  ADDR_RSTSTATUS  = 5'h05;
    localparam logic [4:0]  ADDR_MODE       = 5'h06;
    localparam logic [4:0]  ADDR_TEMP       = 5'h12;
    localparam int          CMD_WRITE_BIT   = 7;

    // ********************************************************************
    // Mode register fields and reset value
    // ********************************************************************
    localparam logic [15:0] MODE_RESET      = 16'h0000;
    localparam int          BIT_HPF_BYP     = 0;
    localparam int          BIT_LPF_BYP     = 1;
    localparam int          BIT_PULSE_DIS   = 2;
    localparam int          BIT_DIP_DIS     = 3;
    localparam int          BIT_ADC_PD      = 4;
    localparam int          BIT_TEMP_START  = 5;
    localparam int          BIT_SOFT_RST    = 6;
    localparam int          BIT_HALF_CYC    = 7;
    localparam int          BIT_SHORT_A     = 8;
    localparam int          BIT_SHORT_B     = 9;
    localparam int          BIT_SWAP        = 10;
    localparam int          RATE_LSB        = 11;
    localparam int          SRC_LSB         = 13;
    localparam int          BIT_TEST        = 15;

    // ********************************************************************
    // Waveform rate and source
    // ********************************************************************
    localparam int          RATE_BASE_DIV   = 128;
    localparam int          RATE_DIV_W      = 10;
    localparam logic [1:0]  WAVE_SRC_BOTH   = 2'h1;
    localparam logic [5:0]  WAVE_LEN_SHORT  = 6'h18;
    localparam logic [5:0]  WAVE_LEN_LONG   = 6'h28;

    // ********************************************************************
    // Status flags and reset value
    // ********************************************************************
    localparam int          STAT_TEMP       = 5;
    localparam logic [7:0]  STATUS_RESET    = 8'h40;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int          CLK_MHZ         = 100;
    localparam int          SOFT_RESET_US   = 18;
    localparam int          SOFT_RESET_CYC  = SOFT_RESET_US * CLK_MHZ;
    localparam int          SOFT_CNT_W      = 11;

    // Data length in bits of a register access
    function automatic logic [4:0] mmc_reg_bits(input logic [4:0] addr);
        mmc_reg_bits = (addr == ADDR_MODE) ? 5'h10 : 5'h08;
    endfunction : mmc_reg_bits

endpackage : mmc_pkg

/* src/mmc_rate_div.sv */
// Waveform sample rate divider: one-cycle strobe every 128 << code clocks.
// Assumes the select code comes from logic on the same clock.
`timescale 1ns/10ps
module mmc_rate_div
    import mmc_pkg::*;
#(
    parameter int DIV_W = RATE_DIV_W
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic [1:0] rate_sel,
    // Strobe
    output logic            tick
);

    logic [DIV_W-1:0] count;
    wire  [DIV_W-1:0] last_count = DIV_W'((RATE_BASE_DIV << rate_sel) - 1);

    // ********************************************************************
    // Free-running counter, restarts on wrap or a shortened period
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count >= last_count) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule : mmc_rate_div

/* src/mmc_serial_port.sv */
// Serial register port: command byte, then 8 or 16 data bits, MSB first.
// Assumes pins are asynchronous; each passes two flip-flops before use.
`timescale 1ns/10ps
module mmc_serial_port
    import mmc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Serial pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    // Register side
    input  wire logic [15:0] rd_data,
    output logic [4:0]       acc_addr,
    output logic [15:0]      wr_data,
    output logic             wr_pulse,
    output logic             rd_done
);

    typedef enum logic {ST_CMD, ST_DATA} mmc_ser_state_t;

    mmc_ser_state_t state;
    logic [2:0]     sync1;
    logic [2:0]     sync2;
    logic           sclk_prev;
    logic [4:0]     count;
    logic [4:0]     len;
    logic           is_write;
    logic           load_pend;
    logic [15:0]    shift_in;
    logic [15:0]    shift_out;

    // Synchronised pins and edges
    wire        sclk_s   = sync2[0];
    wire        cs_n_s   = sync2[1];
    wire        din_s    = sync2[2];
    wire        rise     = sclk_s & ~sclk_prev;
    wire        fall     = ~sclk_s & sclk_prev;
    wire [15:0] in_next  = {shift_in[14:0], din_s};
    wire [4:0]  addr_new = in_next[4:0];
    wire [4:0]  out_sh   = 5'h10 - len;

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1     <= 3'h2;
            sync2     <= 3'h2;
            sclk_prev <= 1'b0;
        end else begin
            sync1     <= {din, cs_n, sclk};
            sync2     <= sync1;
            sclk_prev <= sync2[0];
        end
    end

    // ********************************************************************
    // Command and data shifting
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state     <= ST_CMD;
            count     <= 5'h00;
            len       <= 5'h08;
            is_write  <= 1'b0;
            load_pend <= 1'b0;
            shift_in  <= 16'h0000;
            shift_out <= 16'h0000;
            acc_addr  <= 5'h00;
            wr_data   <= 16'h0000;
            wr_pulse  <= 1'b0;
            rd_done   <= 1'b0;
            dout      <= 1'b0;
        end else begin
            wr_pulse  <= 1'b0;
            rd_done   <= 1'b0;
            load_pend <= 1'b0;
            if (cs_n_s) begin
                state <= ST_CMD;
                count <= 5'h00;
                dout  <= 1'b0;
            end else if (load_pend) begin
                // Read data aligned to the top of the shifter
                shift_out <= rd_data << out_sh;
            end else if (rise) begin
                shift_in <= in_next;
                case (state)
                    ST_CMD: begin
                        if (count == 5'h07) begin
                            acc_addr  <= addr_new;
                            is_write  <= in_next[CMD_WRITE_BIT];
                            len       <= mmc_reg_bits(addr_new);
                            load_pend <= 1'b1;
                            count     <= 5'h00;
                            state     <= ST_DATA;
                        end else begin
                            count <= count + 5'h01;
                        end
                    end
                    ST_DATA: begin
                        if (count == len - 5'h01) begin
                            wr_pulse <= is_write;
                            rd_done  <= ~is_write;
                            wr_data  <= in_next;
                            count    <= 5'h00;
                            state    <= ST_CMD;
                        end else begin
                            count <= count + 5'h01;
                        end
                    end
                    default: state <= ST_CMD;
                endcase
            end else if (fall && state == ST_DATA && !is_write) begin
                dout      <= shift_out[15];
                shift_out <= {shift_out[14:0], 1'b0};
            end
        end
    end

endmodule : mmc_serial_port

/* testbench/metering_mode_control_register_tb.sv */
// Self-checking bench for the mode control block with a serial host model.
// Assumes mmc_pkg and the design files are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module metering_mode_control_register_tb
    import mmc_pkg::*;
;
    // ********************************************************************
    // Signals and instances
    // ********************************************************************
    logic        sys_clk = 1'b0;
    logic        rst_n, sclk, cs_n, din, dout, temp_done, power_pulse_raw;
    logic [7:0]  temp_result;
    logic        hpf, lpf, dip, acc, pd, sha, shb, swp, tcs, tst, strobe, pls, crst_n;
    logic [1:0]  src;
    logic [5:0]  len;
    logic        rd_valid;
    logic [15:0] rd_word, v, ev, r, lfsr;
    logic [15:0] exp_q[$];
    int          error_cnt, cmp_count, n, i, c;

    mmc_mode_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .temp_done(temp_done), .temp_result(temp_result),
        .power_pulse_raw(power_pulse_raw), .highpass_bypass(hpf),
        .power_lowpass_bypass(lpf), .dip_detect_disable(dip),
        .half_cycle_accumulate_mode(acc), .converter_powerdown(pd),
        .chan_a_input_short(sha), .chan_b_input_short(shb), .adc_input_swap(swp),
        .temperature_convert_start(tcs), .factory_test_enable(tst),
        .waveform_source_select(src), .waveform_sample_len(len),
        .waveform_sample_strobe(strobe), .power_pulse_output(pls),
        .chip_reset_n(crst_n));
    mmc_host_model host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .rd_valid(rd_valid), .rd_word(rd_word));

    always #5 sys_clk = ~sys_clk;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [15:0] next_rand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : next_rand

    task automatic wr_mode(input logic [15:0] d);
        host.access({3'b100, ADDR_MODE}, d, 16);
    endtask : wr_mode

    // Note the expected word, then read it back
    task automatic rd(input logic [4:0] a, input int nb, input logic [15:0] e);
        exp_q.push_back(e);
        host.access({3'b000, a}, 16'h0000, nb);
    endtask : rd

    task automatic check_outs(input logic [15:0] m);
        `CHK("hpf", m[0], hpf)
        `CHK("lpf", m[1], lpf)
        `CHK("dip", m[3], dip)
        `CHK("pd", m[4], pd)
        `CHK("tcs", m[5], tcs)
        `CHK("acc", m[7], acc)
        `CHK("sha", m[8], sha)
        `CHK("shb", m[9], shb)
        `CHK("swap", m[10], swp)
        `CHK("src", m[14:13], src)
        `CHK("len", (m[14:13] == 2'b01) ? 6'h28 : 6'h18, len)
        `CHK("test", m[15], tst)
    endtask : check_outs

    task automatic wait_strobe();
        n = 0;
        do begin host.tick(1); n++; end while (strobe !== 1'b1 && n < 3000);
    endtask : wait_strobe

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Read results taken off the queue as they appear
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            ev = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
            `CHK("read_data", ev, rd_word)
        end
    end

    // Watchdog against hangs
    initial begin
        #800000;
        error_cnt++;
        summarize();
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        rst_n = 1'b0; temp_done = 1'b0; temp_result = 8'h00; power_pulse_raw = 1'b0;
        lfsr = 16'hB6AD;
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        host.tick(5);
        check_outs(16'h0000);
        rd(5'h05, 8, 16'h0040);
        rd(5'h04, 8, 16'h0000);
        rd(5'h1F, 8, 16'h0000);
        for (i = 0; i < 10; i++) begin
            v = next_rand() & 16'h7F9F;
            wr_mode(v);
            check_outs(v);
            rd(ADDR_MODE, 16, v);
        end
        host.access(8'h84, 16'h00FF, 8);
        rd(ADDR_MODE, 16, v);
        for (i = 0; i < 16; i++) begin
            if (i != 5 && i != 6) begin
                v = 16'h0001 << i;
                wr_mode(v);
                check_outs(v);
            end
        end
        for (c = 0; c < 2; c++) begin
            wr_mode(c[0] ? 16'h0004 : 16'h0000);
            repeat (4) begin
                r = next_rand();
                power_pulse_raw = r[0];
                host.tick(1);
                `CHK("pulse", r[0] & ~c[0], pls)
            end
        end
        wr_mode(16'h0020);
        `CHK("tcs_set", 1'b1, tcs)
        r = next_rand();
        temp_result = r[7:0];
        temp_done = 1'b1;
        host.tick(1);
        temp_done = 1'b0;
        host.tick(2);
        `CHK("tcs_clr", 1'b0, tcs)
        rd(5'h04, 8, 16'h0020);
        rd(5'h12, 8, {8'h00, r[7:0]});
        rd(ADDR_MODE, 16, 16'h0000);
        temp_done = 1'b1;
        rd(5'h05, 8, 16'h0020);
        temp_done = 1'b0;
        rd(5'h04, 8, 16'h0020);
        for (c = 0; c < 4; c++) begin
            v = {1'b0, c[1:0], c[1:0], 11'h000};
            wr_mode(v);
            check_outs(v);
            wait_strobe();
            wait_strobe();
            wait_strobe();
            `CHK("rate", 128 << c, n)
        end
        rst_n = 1'b0;
        host.tick(3);
        rst_n = 1'b1;
        host.tick(5);
        check_outs(16'h0000);
        rd(5'h05, 8, 16'h0040);
        wr_mode(16'h0040);
        `CHK("soft_low", 1'b0, crst_n)
        n = 0;
        while (crst_n !== 1'b1 && n < 3000) begin host.tick(1); n++; end
        `CHK("soft_len", 1'b1, (n >= 1700 && n <= 1800))
        check_outs(16'h0000);
        host.tick(5);
        rd(5'h04, 8, 16'h0040);
        rd(ADDR_MODE, 16, 16'h0000);
        host.tick(5);
        summarize();
    end
endmodule : metering_mode_control_register_tb

/* testbench/mmc_host_model.sv */
// Host model that drives the serial register pins of the mode block.
// Assumes sys_clk is the block clock; pins change just after its edges.
`timescale 1ns/10ps
module mmc_host_model
    import mmc_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Serial pins
    output logic             sclk,
    output logic             cs_n,
    output logic             din,
    input  wire logic        dout,
    // Read result
    output logic             rd_valid,
    output logic [15:0]      rd_word
);
    // ********************************************************************
    // Idle levels and serial access
    // ********************************************************************
    initial begin
        sclk     = 1'b0;
        cs_n     = 1'b1;
        din      = 1'b0;
        rd_valid = 1'b0;
        rd_word  = 16'h0000;
    end

    // Wait n edges, land just after the last
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Command byte then nbits data, MSB first, 5 clocks per clock phase
    task automatic access(input logic [7:0] cmd, input logic [15:0] wdat,
                          input int nbits);
        logic [23:0] sh;
        logic [15:0] got;
        int          i;
        sh   = {cmd, (nbits == 16) ? wdat : {wdat[7:0], 8'h00}};
        got  = 16'h0000;
        tick(1);
        cs_n = 1'b0;
        for (i = 0; i < 8 + nbits; i++) begin
            din  = sh[23 - i];
            tick(5);
            sclk = 1'b1;
            if (i >= 8) begin
                got = {got[14:0], dout};
            end
            tick(5);
            sclk = 1'b0;
        end
        tick(2);
        cs_n = 1'b1;
        din  = ~din;  // Released line shows no stale level
        tick(5);
        if (!cmd[7]) begin
            rd_word  = got;
            rd_valid = 1'b1;
            tick(1);
            rd_valid = 1'b0;
        end
    endtask : access
endmodule : mmc_host_model
